// [logic/fcd_control_decode_defines.vh]
/*
 * Constants for the floating-point unit control and decode block:
 * register offsets, field positions, reset values and decode codes.
 * Assumes inclusion by its bare name from the design file.
 */
`ifndef FCD_CONTROL_DECODE_DEFINES_VH
`define FCD_CONTROL_DECODE_DEFINES_VH

// Register byte offsets
`define FCD_CTRL_OFF 12'h000
`define FCD_STAT_OFF 12'h004
`define FCD_RES_OFF 12'h008

// Control register field positions
`define FCD_INSTR_LSB 0
`define FCD_BYPASS_LSB 10
`define FCD_TEMP_EDGE_BIT 13
`define FCD_SSEL_LSB 14
`define FCD_HALF_BIT 16
`define FCD_RES_EN_N_BIT 17
`define FCD_STAT_EN_N_BIT 18
`define FCD_COND_EN_N_BIT 19
`define FCD_STALL_N_BIT 20

// Control register reset: all enables off, stall released, bypass all
`define FCD_CTRL_RESET 32'h001EDC00

// Instruction fields
`define FCD_I_MODE 9
`define FCD_I_PREC_A 8
`define FCD_I_PREC_B 7
`define FCD_I_UNIT 6

// Unit code of bits 6-5 in independent mode
`define FCD_UNIT_ALU2 2'h0
`define FCD_UNIT_ALU1 2'h1
`define FCD_UNIT_MUL 2'h2

// Status source select: both high follows the output source
`define FCD_SSEL_FOLLOW 2'h3

`endif

// [logic/fcd_control_decode.v]
/*
 * Control and decode block of a microprogrammed floating-point unit.
 * Software sets instruction, bypass, select, enable and stall bits over
 * APB; the block latches the instruction, decodes it into datapath
 * controls, steers result halves and status onto the output buses.
 * Assumes the arithmetic datapath supplies result halves, unit status,
 * exception and denormal flags synchronous to pclk.
 */
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "fcd_control_decode_defines.vh"

module fcd_control_decode #(
  parameter STAT_W = 8,
  parameter [1:0] SSEL_FORCE_ALU = 2'h1,
  parameter [1:0] SSEL_FORCE_MUL = 2'h2
) (
  input wire pclk, // Bus and device clock
  input wire presetn, // Asynchronous reset, low active
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB write
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error on unmapped address
  input wire [31:0] result_lo, // Datapath result low half
  input wire [31:0] result_hi, // Datapath result high half
  input wire [STAT_W-1:0] alu_status, // ALU status flags
  input wire [STAT_W-1:0] mul_status, // Multiplier status flags
  input wire [3:0] alu_condition, // ALU compare conditions
  input wire alu_exception, // ALU raised an exception
  input wire mul_exception, // Multiplier raised an exception
  input wire a_denormal_in, // A operand is a denormal
  input wire b_denormal_in, // B operand is a denormal
  output reg [31:0] result_bus, // Selected result half
  output reg result_bus_oe, // Result bus driven
  output reg [STAT_W-1:0] status_bus, // Selected status
  output reg status_bus_oe, // Status bus driven
  output reg [3:0] condition_bus, // Condition outputs
  output reg condition_bus_oe, // Condition bus driven
  output reg chained_exception_flag, // Deselected unit exception
  output reg mode_chained, // Chained operation
  output reg out_source_mul, // Output source is multiplier
  output reg alu_active, // ALU operation decoded
  output reg mul_active, // Multiplier operation decoded
  output reg alu_one_operand, // One-operand ALU operation
  output reg [4:0] alu_function, // One-operand function code
  output reg [1:0] alu_op, // Two-operand or chained ALU op
  output reg abs_a, // Absolute value of A
  output reg abs_b, // Absolute value of B
  output reg abs_y, // Absolute value of ALU result
  output reg neg_alu, // Negate ALU result
  output reg neg_mul, // Negate multiplier result
  output reg wrapped_a, // A operand wrapped format
  output reg wrapped_b, // B operand wrapped format
  output reg alu_b_zero, // Force ALU B to zero
  output reg mul_b_one, // Force multiplier B to one
  output reg prec_a_double, // A operand double precision
  output reg prec_b_double, // B operand double precision
  output reg result_double, // Result double precision
  output reg mul_input_invalid, // Denormal reaches multiplier
  output reg temp_load_fall, // Temp register loads on falling edge
  output reg stalled // Device frozen
);

  reg [31:0] ctrl_q;
  reg [9:0] instr_q;
  reg [STAT_W-1:0] stat_hold_q;
  reg [3:0] cond_hold_q;
  reg [STAT_W-1:0] stat_sel;
  reg [STAT_W-1:0] stat_src;
  reg [3:0] cond_src;
  reg sel_mul_status;
  reg [31:0] rd_d;
  reg err_d;
  wire [9:0] instr_field;
  wire [2:0] register_bypass_select;
  wire [1:0] status_source_select;
  wire result_half_select;
  wire result_bus_enable_n;
  wire status_bus_enable_n;
  wire condition_bus_enable_n;
  wire stall_n;
  wire run;
  wire acc;
  wire [1:0] unit_code;
  wire chained;
  wire res_dbl;

  assign instr_field = ctrl_q[`FCD_INSTR_LSB+9:`FCD_INSTR_LSB];
  assign register_bypass_select = ctrl_q[`FCD_BYPASS_LSB+2:`FCD_BYPASS_LSB];
  assign status_source_select = ctrl_q[`FCD_SSEL_LSB+1:`FCD_SSEL_LSB];
  assign result_half_select = ctrl_q[`FCD_HALF_BIT];
  assign result_bus_enable_n = ctrl_q[`FCD_RES_EN_N_BIT];
  assign status_bus_enable_n = ctrl_q[`FCD_STAT_EN_N_BIT];
  assign condition_bus_enable_n = ctrl_q[`FCD_COND_EN_N_BIT];
  assign stall_n = ctrl_q[`FCD_STALL_N_BIT];
  assign run = stall_n;
  assign acc = psel & penable;

  assign unit_code = instr_q[6:5];
  assign chained = instr_q[`FCD_I_MODE];
  assign res_dbl = instr_q[`FCD_I_PREC_A] | instr_q[`FCD_I_PREC_B];

  // APB slave: one wait state, data and error from flops
  always @* begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    case (paddr)
      `FCD_CTRL_OFF: rd_d = ctrl_q;
      `FCD_STAT_OFF: rd_d = {stalled, chained_exception_flag, mul_input_invalid,
                             mode_chained, out_source_mul, 15'h0000,
                             {(12-STAT_W){1'b0}}, stat_sel};
      `FCD_RES_OFF: rd_d = result_bus;
      default: err_d = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      ctrl_q <= `FCD_CTRL_RESET;
    end else begin
      pready <= acc & ~pready;
      if (acc & ~pready) begin
        prdata <= pwrite ? 32'h00000000 : rd_d;
        pslverr <= err_d;
      end
      if (acc & pready & pwrite & (paddr == `FCD_CTRL_OFF))
        ctrl_q <= pwdata;
    end
  end

  // Status source choice
  always @* begin
    if (status_source_select == `FCD_SSEL_FOLLOW)
      sel_mul_status = instr_q[`FCD_I_UNIT];
    else if (status_source_select == SSEL_FORCE_MUL)
      sel_mul_status = 1'b1;
    else if (status_source_select == SSEL_FORCE_ALU)
      sel_mul_status = 1'b0;
    else
      sel_mul_status = instr_q[`FCD_I_UNIT];
    stat_src = sel_mul_status ? mul_status : alu_status;
    cond_src = alu_condition;
    // Transparent unless output registers are enabled
    stat_sel = register_bypass_select[2] ? stat_src : stat_hold_q;
  end

  // Instruction latch, status register and decode, frozen while stalled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= 10'h000;
      stat_hold_q <= {STAT_W{1'b0}};
      cond_hold_q <= 4'h0;
      stalled <= 1'b0;
      temp_load_fall <= 1'b0;
      mode_chained <= 1'b0;
      out_source_mul <= 1'b0;
      alu_active <= 1'b0;
      mul_active <= 1'b0;
      alu_one_operand <= 1'b0;
      alu_function <= 5'h00;
      alu_op <= 2'h0;
      abs_a <= 1'b0;
      abs_b <= 1'b0;
      abs_y <= 1'b0;
      neg_alu <= 1'b0;
      neg_mul <= 1'b0;
      wrapped_a <= 1'b0;
      wrapped_b <= 1'b0;
      alu_b_zero <= 1'b0;
      mul_b_one <= 1'b0;
      prec_a_double <= 1'b0;
      prec_b_double <= 1'b0;
      result_double <= 1'b0;
      mul_input_invalid <= 1'b0;
      chained_exception_flag <= 1'b0;
    end else begin
      stalled <= ~stall_n;
      temp_load_fall <= ctrl_q[`FCD_TEMP_EDGE_BIT];
      if (run) begin
        instr_q <= instr_field;
        if (!register_bypass_select[2]) begin
          stat_hold_q <= stat_src;
          cond_hold_q <= cond_src;
        end
        mode_chained <= chained;
        out_source_mul <= instr_q[`FCD_I_UNIT];
        prec_a_double <= instr_q[`FCD_I_PREC_A];
        prec_b_double <= instr_q[`FCD_I_PREC_B];
        result_double <= res_dbl;
        if (chained) begin
          alu_active <= 1'b1;
          mul_active <= 1'b1;
          alu_one_operand <= 1'b0;
          alu_function <= 5'h00;
          alu_op <= instr_q[1:0];
          alu_b_zero <= instr_q[5];
          mul_b_one <= instr_q[4];
          neg_alu <= instr_q[3];
          neg_mul <= instr_q[2];
          abs_a <= 1'b0;
          abs_b <= 1'b0;
          abs_y <= 1'b0;
          wrapped_a <= 1'b0;
          wrapped_b <= 1'b0;
          mul_input_invalid <= 1'b0;
          chained_exception_flag <= instr_q[`FCD_I_UNIT] ? alu_exception : mul_exception;
        end else begin
          chained_exception_flag <= 1'b0;
          alu_b_zero <= 1'b0;
          mul_b_one <= 1'b0;
          neg_alu <= 1'b0;
          case (unit_code)
            `FCD_UNIT_ALU2: begin
              alu_active <= 1'b1;
              mul_active <= 1'b0;
              alu_one_operand <= 1'b0;
              alu_function <= 5'h00;
              alu_op <= instr_q[1:0];
              abs_a <= instr_q[4];
              abs_b <= instr_q[3];
              abs_y <= instr_q[2];
              neg_mul <= 1'b0;
              wrapped_a <= 1'b0;
              wrapped_b <= 1'b0;
              mul_input_invalid <= 1'b0;
            end
            `FCD_UNIT_ALU1: begin
              alu_active <= 1'b1;
              mul_active <= 1'b0;
              alu_one_operand <= 1'b1;
              alu_function <= instr_q[4:0];
              alu_op <= 2'h0;
              abs_a <= 1'b0;
              abs_b <= 1'b0;
              abs_y <= 1'b0;
              neg_mul <= 1'b0;
              wrapped_a <= 1'b0;
              wrapped_b <= 1'b0;
              mul_input_invalid <= 1'b0;
            end
            default: begin
              alu_active <= 1'b0;
              mul_active <= 1'b1;
              alu_one_operand <= 1'b0;
              alu_function <= 5'h00;
              alu_op <= 2'h0;
              abs_a <= instr_q[4];
              abs_b <= instr_q[3];
              abs_y <= 1'b0;
              neg_mul <= instr_q[2];
              wrapped_a <= instr_q[1];
              wrapped_b <= instr_q[0];
              // Widening leaves a denormal unnormalised
              mul_input_invalid <= a_denormal_in | b_denormal_in;
            end
          endcase
        end
      end
    end
  end

  // Output steering uses control bits, the decoded result precision and the status source choice
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_bus <= 32'h00000000;
      result_bus_oe <= 1'b0;
      status_bus <= {STAT_W{1'b0}};
      status_bus_oe <= 1'b0;
      condition_bus <= 4'h0;
      condition_bus_oe <= 1'b0;
    end else if (run) begin
      result_bus_oe <= ~result_bus_enable_n;
      if (result_bus_enable_n)
        result_bus <= 32'h00000000;
      else if (result_double & result_half_select)
        result_bus <= result_hi;
      else
        result_bus <= result_lo;
      status_bus_oe <= ~status_bus_enable_n;
      status_bus <= status_bus_enable_n ? {STAT_W{1'b0}} : stat_sel;
      condition_bus_oe <= ~condition_bus_enable_n;
      condition_bus <= condition_bus_enable_n ? 4'h0 :
                       (register_bypass_select[2] ? cond_src : cond_hold_q);
    end
  end

endmodule // fcd_control_decode
`default_nettype wire

// [verif/fcd_control_decode_assertions.sv]
/* Checker for the control and decode block outputs.
   Bound to the top module; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module fcd_control_decode_assertions #(
  parameter int STAT_W = 8
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low active
  input wire logic [31:0] result_bus, // Result half
  input wire logic result_bus_oe, // Result driven
  input wire logic [STAT_W-1:0] status_bus, // Status
  input wire logic status_bus_oe, // Status driven
  input wire logic [3:0] condition_bus, // Conditions
  input wire logic condition_bus_oe, // Conditions driven
  input wire logic mode_chained, // Chained mode
  input wire logic out_source_mul, // Source multiplier
  input wire logic alu_active, // ALU decoded
  input wire logic mul_active, // Multiplier decoded
  input wire logic alu_b_zero, // ALU B forced zero
  input wire logic mul_b_one, // Multiplier B forced one
  input wire logic wrapped_a, // A wrapped
  input wire logic wrapped_b, // B wrapped
  input wire logic [1:0] alu_op, // ALU op
  input wire logic prec_a_double, // A double
  input wire logic prec_b_double, // B double
  input wire logic result_double, // Result double
  input wire logic mul_input_invalid, // Denormal to multiplier
  input wire logic stalled // Frozen
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_RES_IDLE: assert property (!result_bus_oe |-> result_bus == 32'h0)
    else $error("Result bus not idle while disabled");
  AST_STAT_IDLE: assert property (!status_bus_oe |-> status_bus == '0)
    else $error("Status bus not idle while disabled");
  AST_COND_IDLE: assert property (!condition_bus_oe |-> condition_bus == 4'h0)
    else $error("Condition bus not idle while disabled");
  AST_ONE_UNIT: assert property (!mode_chained |-> !(alu_active && mul_active))
    else $error("Both units active in independent mode");
  AST_FORCE_CHAIN: assert property ((alu_b_zero || mul_b_one) |-> mode_chained)
    else $error("Forced operand outside chained mode");
  AST_NO_WRAP_CHAIN: assert property (mode_chained |-> !wrapped_a && !wrapped_b)
    else $error("Wrapped operand in chained mode");
  AST_DENORM_MUL: assert property (mul_input_invalid |-> mul_active && !mode_chained)
    else $error("Invalid input flag without multiply");
  AST_MIXED_DOUBLE: assert property (result_double == (prec_a_double || prec_b_double))
    else $error("Result precision wrong");
  AST_STALL_FREEZE: assert property (stalled && $past(stalled) |->
    $stable({mode_chained, out_source_mul, alu_op, prec_a_double, result_bus}))
    else $error("Outputs moved while stalled");
  cover property (stalled ##1 !stalled);
  cover property (mode_chained && out_source_mul);
  cover property (status_bus_oe && result_bus_oe);
endmodule // fcd_control_decode_assertions
bind fcd_control_decode fcd_control_decode_assertions #(.STAT_W(STAT_W)) i_chk (.pclk, .presetn, .result_bus,
  .result_bus_oe, .status_bus, .status_bus_oe, .condition_bus, .condition_bus_oe, .mode_chained,
  .out_source_mul, .alu_active, .mul_active, .alu_b_zero, .mul_b_one, .wrapped_a, .wrapped_b, .alu_op,
  .prec_a_double, .prec_b_double, .result_double, .mul_input_invalid, .stalled);
`default_nettype wire

// [verif/fcd_datapath_model.sv]
/* Datapath stand-in: fixed result halves and status, flags on request.
   Assumes the bench raises requests after a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module fcd_datapath_model #(
  parameter logic [31:0] LO = 32'h0,
  parameter logic [31:0] HI = 32'h0,
  parameter logic [7:0] AST = 8'h0,
  parameter logic [7:0] MST = 8'h0
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low active
  input wire logic alu_exc_req, // Raise ALU exception
  input wire logic mul_exc_req, // Raise multiplier exception
  input wire logic den_req, // Mark A denormal
  output logic [31:0] result_lo, // Low half
  output logic [31:0] result_hi, // High half
  output logic [7:0] alu_status, // ALU status
  output logic [7:0] mul_status, // Multiplier status
  output logic [3:0] alu_condition, // Conditions
  output logic alu_exception, // ALU exception
  output logic mul_exception, // Multiplier exception
  output logic a_denormal_in, // A denormal
  output logic b_denormal_in // B denormal
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {result_lo, result_hi, alu_status, mul_status, alu_condition, alu_exception, mul_exception, a_denormal_in,
        b_denormal_in} <= '0;
    end else begin
      {result_lo, result_hi, alu_status, mul_status, alu_condition, alu_exception, mul_exception, a_denormal_in,
        b_denormal_in} <= {LO, HI, AST, MST, 4'hA, alu_exc_req, mul_exc_req, den_req, 1'b0};
    end
  end
endmodule // fcd_datapath_model
`default_nettype wire

// [verif/fcd_control_decode_test.sv]
/* Self-checking bench for the control and decode block.
   Drives APB as master; the datapath model feeds the result and status inputs. */
`timescale 1ns/10ps
`default_nettype none
module fcd_control_decode_test;
  localparam logic [31:0] LO = 32'h0F1E2D3C;
  localparam logic [31:0] HI = 32'hA5B4C3D2;
  localparam logic [7:0] AST = 8'h3C;
  localparam logic [7:0] MST = 8'hC3;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic aexc = 1'b0, mexc = 1'b0, den = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, result_lo, result_hi, result_bus, rd, r1;
  logic [7:0] alu_status, mul_status, status_bus;
  logic [3:0] alu_condition, condition_bus;
  logic [1:0] alu_op;
  logic pready, pslverr, alu_exception, mul_exception, a_denormal_in, b_denormal_in, result_bus_oe, status_bus_oe;
  logic condition_bus_oe, chained_exception_flag, mode_chained, out_source_mul, alu_active, mul_active, abs_a, abs_b;
  logic neg_alu, neg_mul, wrapped_a, wrapped_b, alu_b_zero, mul_b_one, prec_a_double, prec_b_double, result_double;
  logic mul_input_invalid, stalled;
  logic [9:0] ti [4] = '{10'h000, 10'h040, 10'h040, 10'h000};
  logic [1:0] ts [4] = '{2'b11, 2'b11, 2'b01, 2'b10};
  logic [7:0] te [4] = '{AST, MST, AST, MST};
  int errors = 0, total_checks = 0;
  always #12.5 pclk = ~pclk;
  fcd_control_decode i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .result_lo, .result_hi, .alu_status, .mul_status, .alu_condition, .alu_exception, .mul_exception, .a_denormal_in,
    .b_denormal_in, .result_bus, .result_bus_oe, .status_bus, .status_bus_oe, .condition_bus, .condition_bus_oe,
    .chained_exception_flag, .mode_chained, .out_source_mul, .alu_active, .mul_active, .alu_one_operand(),
    .alu_function(), .alu_op, .abs_a, .abs_b, .abs_y(), .neg_alu, .neg_mul, .wrapped_a, .wrapped_b, .alu_b_zero,
    .mul_b_one, .prec_a_double, .prec_b_double, .result_double, .mul_input_invalid, .temp_load_fall(), .stalled);
  fcd_datapath_model #(.LO(LO), .HI(HI), .AST(AST), .MST(MST)) i_dp (.pclk, .presetn, .alu_exc_req(aexc),
    .mul_exc_req(mexc), .den_req(den), .result_lo, .result_hi, .alu_status, .mul_status, .alu_condition,
    .alu_exception, .mul_exception, .a_denormal_in, .b_denormal_in);
  task end_sim;
    $display("Checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
    total_checks++;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Control word: instruction, status select, half, result/status enables, stall
  task set(input logic [9:0] i, input logic [1:0] ss, input logic h, input logic rn, input logic sn, input logic st);
    apb(1'b1, 12'h000, {11'h0, st, sn, sn, rn, h, ss, 1'b0, 3'b111, i});
    repeat (6) @(negedge pclk);
  endtask
  task t_reset;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h001EDC00);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask
  task t_alu;
    for (int op = 0; op < 4; op++) begin
      set({5'b00000, 3'b110, op[1:0]}, 2'b11, 1'b0, 1'b1, 1'b1, 1'b1);
      chk({alu_active, mul_active, mode_chained, abs_a, abs_b, alu_op}, {5'b10011, op[1:0]});
    end
  endtask
  task t_mul;
    set(10'h14E, 2'b11, 1'b0, 1'b1, 1'b1, 1'b1);
    chk({mul_active, alu_active, abs_a, abs_b, neg_mul, wrapped_a, wrapped_b}, 7'b1001110);
    chk({prec_a_double, prec_b_double, result_double, mul_input_invalid}, 4'b1010);
    @(posedge pclk);
    den <= 1'b1;
    repeat (6) @(negedge pclk);
    chk({31'h0, mul_input_invalid}, 32'h1);
    @(posedge pclk);
    den <= 1'b0;
  endtask
  task t_chain;
    @(posedge pclk);
    aexc <= 1'b1;
    set(10'h27A, 2'b11, 1'b0, 1'b1, 1'b1, 1'b1);
    chk({mode_chained, out_source_mul, alu_b_zero, mul_b_one, neg_alu, neg_mul, alu_op}, 8'b11111010);
    chk({31'h0, chained_exception_flag}, 32'h1);
    set(10'h204, 2'b11, 1'b0, 1'b1, 1'b1, 1'b1);
    chk({out_source_mul, neg_alu, neg_mul, alu_b_zero, chained_exception_flag}, 5'b00100);
    @(posedge pclk);
    aexc <= 1'b0;
  endtask
  task t_half;
    set(10'h100, 2'b11, 1'b0, 1'b0, 1'b1, 1'b1);
    chk(result_bus, LO);
    chk({31'h0, result_bus_oe}, 32'h1);
    set(10'h100, 2'b11, 1'b1, 1'b0, 1'b1, 1'b1);
    chk(result_bus, HI);
    set(10'h000, 2'b11, 1'b0, 1'b0, 1'b1, 1'b1);
    r1 = result_bus;
    chk(r1, LO);
    set(10'h000, 2'b11, 1'b1, 1'b0, 1'b1, 1'b1);
    chk(result_bus, LO);
    set(10'h000, 2'b11, 1'b1, 1'b1, 1'b1, 1'b1);
    chk({31'h0, result_bus_oe}, 32'h0);
    chk(result_bus, 32'h0);
  endtask
  task t_status;
    for (int k = 0; k < 4; k++) begin
      set(ti[k], ts[k], 1'b0, 1'b1, 1'b0, 1'b1);
      chk({status_bus_oe, condition_bus_oe, status_bus}, {2'b11, te[k]});
      chk({28'h0, condition_bus}, 32'hA);
      apb(1'b0, 12'h004, 32'h0);
      chk({24'h0, rd[7:0]}, {24'h0, te[k]});
    end
    // Output registers enabled: status taken through the hold register
    apb(1'b1, 12'h000, {11'h0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2'b11, 1'b0, 3'b011, 10'h040});
    repeat (6) @(negedge pclk);
    chk({24'h0, status_bus}, {24'h0, MST});
    chk({28'h0, condition_bus}, 32'hA);
    set(10'h000, 2'b11, 1'b0, 1'b1, 1'b1, 1'b1);
    chk({status_bus_oe, condition_bus_oe}, 2'b00);
  endtask
  task t_stall;
    set(10'h100, 2'b11, 1'b0, 1'b1, 1'b1, 1'b1);
    set(10'h100, 2'b11, 1'b0, 1'b1, 1'b1, 1'b0);
    chk({31'h0, stalled}, 32'h1);
    set(10'h27A, 2'b11, 1'b0, 1'b1, 1'b1, 1'b0);
    chk({mode_chained, prec_a_double}, 2'b01);
    set(10'h27A, 2'b11, 1'b0, 1'b1, 1'b1, 1'b1);
    chk({stalled, mode_chained}, 2'b01);
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_alu;
    t_mul;
    t_chain;
    t_half;
    t_status;
    t_stall;
    end_sim;
  end
  initial begin
    #100000;
    errors++;
    end_sim;
  end
endmodule // fcd_control_decode_test
`default_nettype wire
